// [rtl/fds_fifo.sv]
// 16 x 5 fifo with dual load strobes, unload strobe, flush and status
`timescale 1ns/1ps
module fds_fifo
  import fds_pkg::*;
(
  // system clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // link clock for the write side
  input  wire logic                 link_clk,
  // write side pins
  input  wire logic                 load_strobe_a,
  input  wire logic                 load_strobe_b,
  input  wire logic [FDS_WIDTH-1:0] write_word_in,
  // read side pins
  input  wire logic                 unload_strobe_in,
  input  wire logic                 output_enable_n,
  input  wire logic                 flush_n,
  // three-state data outputs
  output logic      [FDS_WIDTH-1:0] read_word_out,
  output logic      [FDS_WIDTH-1:0] read_word_oe,
  // status outputs
  output logic                      space_available,
  output logic                      head_valid,
  output logic                      unload_pulse_out
);

  // link domain signals
  logic                 link_rst;
  logic                 load_a_s;
  logic                 load_b_s;
  logic [FDS_WIDTH-1:0] load_word_s;
  logic                 load_both;
  logic                 load_both_d_reg;
  logic                 load_edge;
  logic                 capture_pend_reg;
  logic [FDS_WIDTH-1:0] hold_word_reg;
  logic                 push_tog_reg;

  // system domain signals
  logic                 push_tog_s;
  logic                 push_tog_d_reg;
  logic                 push_evt;
  logic                 unload_s;
  logic                 oe_n_s;
  logic                 flush_n_s;
  logic                 unload_d_reg;
  logic                 flush_n_d_reg;
  logic                 pop_evt;
  logic                 flush_evt;
  logic                 do_push;
  logic                 do_pop;

  logic [FDS_WIDTH-1:0] mem [FDS_DEPTH];
  logic [FDS_PTR_W-1:0] wr_ptr_reg;
  logic [FDS_PTR_W-1:0] rd_ptr_reg;
  logic [FDS_CNT_W-1:0] count_reg;
  logic [FDS_CNT_W-1:0] count_next;
  fds_pulse_state_t     pulse_state_reg;
  fds_pulse_state_t     pulse_state_next;
  logic [1:0]           pulse_cnt_reg;
  logic                 vacate_evt;

  fds_sync #(.WIDTH(1)) u_link_rst_sync
  (
    .clk  (link_clk),
    .din  (sys_rst),
    .dout (link_rst)
  );

  fds_sync #(.WIDTH(FDS_WIDTH + 2)) u_load_sync
  (
    .clk  (link_clk),
    .din  ({load_strobe_a, load_strobe_b, write_word_in}),
    .dout ({load_a_s, load_b_s, load_word_s})
  );

  // a load edge needs the other strobe high, so a low strobe inhibits
  assign load_both = load_a_s & load_b_s;
  assign load_edge = load_both & ~load_both_d_reg;

  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      load_both_d_reg <= 1'b1;
    end
    else
    begin
      load_both_d_reg <= load_both;
    end
  end

  // data may settle after the strobe edge, so sample one link cycle late
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      capture_pend_reg <= 1'b0;
    end
    else
    begin
      capture_pend_reg <= load_edge;
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      hold_word_reg <= FDS_WORD_RST;
      push_tog_reg  <= 1'b0;
    end
    else if (capture_pend_reg)
    begin
      hold_word_reg <= load_word_s;
      push_tog_reg  <= ~push_tog_reg;
    end
  end

  // hold_word_reg changes with each toggle and is stable for several link cycles after it
  fds_sync #(.WIDTH(1)) u_push_sync
  (
    .clk  (clk),
    .din  (push_tog_reg),
    .dout (push_tog_s)
  );

  fds_sync #(.WIDTH(3)) u_read_sync
  (
    .clk  (clk),
    .din  ({unload_strobe_in, output_enable_n, flush_n}),
    .dout ({unload_s, oe_n_s, flush_n_s})
  );

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      push_tog_d_reg <= 1'b0;
    end
    else
    begin
      push_tog_d_reg <= push_tog_s;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      unload_d_reg  <= 1'b1;
      flush_n_d_reg <= 1'b1;
    end
    else
    begin
      unload_d_reg  <= unload_s;
      flush_n_d_reg <= flush_n_s;
    end
  end

  assign push_evt  = push_tog_s ^ push_tog_d_reg;
  assign pop_evt   = unload_s & ~unload_d_reg;
  assign flush_evt = ~flush_n_s & flush_n_d_reg;

  // live count, not the registered flag, so a full buffer never overflows
  assign do_push = push_evt & (count_reg != FDS_CNT_FULL);
  assign do_pop  = pop_evt & (count_reg != FDS_CNT_EMPTY);

  always_ff @(posedge clk)
  begin
    if (do_push & ~flush_evt)
    begin
      mem[wr_ptr_reg] <= hold_word_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst | flush_evt)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr_reg <= wr_ptr_reg + FDS_PTR_ONE;
      end
      if (do_pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + FDS_PTR_ONE;
      end
    end
  end

  always_comb
  begin
    count_next = count_reg;
    if (flush_evt)
    begin
      count_next = FDS_CNT_EMPTY;
    end
    else if (do_push & ~do_pop)
    begin
      count_next = count_reg + FDS_CNT_ONE;
    end
    else if (do_pop & ~do_push)
    begin
      count_next = count_reg - FDS_CNT_ONE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      count_reg <= FDS_CNT_EMPTY;
    end
    else
    begin
      count_reg <= count_next;
    end
  end

  // flush keeps the last presented word on the pins
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      read_word_out <= FDS_WORD_RST;
    end
    else if (~flush_evt & (count_reg != FDS_CNT_EMPTY))
    begin
      read_word_out <= mem[rd_ptr_reg];
    end
  end

  // one enable per pin; the common enable is fanned out here
  genvar gi;
  generate
    for (gi = 0; gi < FDS_WIDTH; gi++)
    begin : g_oe
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          read_word_oe[gi] <= 1'b0;
        end
        else
        begin
          read_word_oe[gi] <= ~oe_n_s;
        end
      end
    end
  endgenerate

  // masked in the pop cycle so the stale head is never flagged valid
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      head_valid <= 1'b0;
    end
    else
    begin
      head_valid <= (count_reg != FDS_CNT_EMPTY) & unload_s & ~pop_evt & ~flush_evt;
    end
  end

  // pins are plain levels, so status can feed a following buffer stage
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      space_available <= 1'b1;
    end
    else
    begin
      space_available <= (count_next != FDS_CNT_FULL);
    end
  end

  // last location vacated by a pop or a flush from full
  assign vacate_evt = (count_reg == FDS_CNT_FULL) & (count_next != FDS_CNT_FULL);

  always_comb
  begin
    pulse_state_next = pulse_state_reg;
    unique case (pulse_state_reg)
      FDS_PULSE_IDLE:
      begin
        if (vacate_evt)
        begin
          pulse_state_next = FDS_PULSE_LOW;
        end
      end
      FDS_PULSE_LOW:
      begin
        if (pulse_cnt_reg == FDS_PULSE_LAST)
        begin
          pulse_state_next = FDS_PULSE_IDLE;
        end
      end
      default:
      begin
        pulse_state_next = FDS_PULSE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pulse_state_reg <= FDS_PULSE_IDLE;
    end
    else
    begin
      pulse_state_reg <= pulse_state_next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst | (pulse_state_reg != FDS_PULSE_LOW))
    begin
      pulse_cnt_reg <= 2'h0;
    end
    else
    begin
      pulse_cnt_reg <= pulse_cnt_reg + 2'h1;
    end
  end

  // low for a fixed width that meets the minimum pulse time
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      unload_pulse_out <= 1'b1;
    end
    else
    begin
      unload_pulse_out <= (pulse_state_next != FDS_PULSE_LOW);
    end
  end

endmodule : fds_fifo

// [rtl/fds_pkg.sv]
// constants shared by the dual-strobe fifo and its helpers
package fds_pkg;

  localparam int FDS_DEPTH = 16;
  localparam int FDS_WIDTH = 5;
  localparam int FDS_PTR_W = 4;
  localparam int FDS_CNT_W = 5;

  localparam logic [FDS_CNT_W-1:0] FDS_CNT_FULL  = 5'h10;
  localparam logic [FDS_CNT_W-1:0] FDS_CNT_EMPTY = 5'h00;
  localparam logic [FDS_PTR_W-1:0] FDS_PTR_ONE   = 4'h1;
  localparam logic [FDS_CNT_W-1:0] FDS_CNT_ONE   = 5'h01;
  localparam logic [FDS_WIDTH-1:0] FDS_WORD_RST  = 5'h00;

  localparam int FDS_CLK_PERIOD_PS  = 4000;
  localparam int FDS_STROBE_MAX_MHZ = 10;
  localparam int FDS_STROBE_MIN_NS  = 1000 / FDS_STROBE_MAX_MHZ;

  localparam int FDS_UNLOAD_PULSE_NS  = 7;
  localparam int FDS_UNLOAD_PULSE_CYC =
    (FDS_UNLOAD_PULSE_NS * 1000 + FDS_CLK_PERIOD_PS - 1) / FDS_CLK_PERIOD_PS;
  localparam logic [1:0] FDS_PULSE_LAST = 2'(FDS_UNLOAD_PULSE_CYC - 1);

  typedef enum logic [1:0]
  {
    FDS_PULSE_IDLE = 2'b01,
    FDS_PULSE_LOW  = 2'b10
  } fds_pulse_state_t;

endpackage : fds_pkg

// [rtl/fds_sync.sv]
// two-stage level synchroniser
`timescale 1ns/1ps
module fds_sync
  import fds_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // destination clock
  input  wire logic             clk,
  // asynchronous level in
  input  wire logic [WIDTH-1:0] din,
  // synchronised level out
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    meta_reg <= din;
    dout     <= meta_reg;
  end

endmodule : fds_sync

// [test/fds_fifo_chk.sv]
// port assertions for the dual-strobe fifo
`timescale 1ns/1ps
module fds_fifo_chk
  import fds_pkg::*;
(
  // clocks and reset
  input wire logic                 clk,
  input wire logic                 sys_rst,
  input wire logic                 link_clk,
  // pins in
  input wire logic                 load_strobe_a,
  input wire logic                 load_strobe_b,
  input wire logic                 unload_strobe_in,
  input wire logic                 output_enable_n,
  input wire logic                 flush_n,
  input wire logic [FDS_WIDTH-1:0] write_word_in,
  // pins out
  input wire logic [FDS_WIDTH-1:0] read_word_out,
  input wire logic [FDS_WIDTH-1:0] read_word_oe,
  input wire logic                 space_available,
  input wire logic                 head_valid,
  input wire logic                 unload_pulse_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_hv_low; !unload_strobe_in [*3] |=> !head_valid; endproperty
  a_hv_low: assert property (p_hv_low) else $error("head valid with unload low");
  property p_oe_off; output_enable_n [*5] |-> read_word_oe == 5'h00; endproperty
  a_oe_off: assert property (p_oe_off) else $error("data driven while disabled");
  property p_oe_on; !output_enable_n [*5] |-> read_word_oe == 5'h1f; endproperty
  a_oe_on: assert property (p_oe_on) else $error("data not driven while enabled");
  property p_leave_full; $rose(space_available) |-> !unload_pulse_out; endproperty
  a_leave_full: assert property (p_leave_full) else $error("no pulse leaving full");
  property p_pulse_w; $fell(unload_pulse_out) |=> !unload_pulse_out ##1 unload_pulse_out; endproperty
  a_pulse_w: assert property (p_pulse_w) else $error("unload pulse width");
  property p_pulse_cause; $fell(unload_pulse_out) |-> $rose(space_available); endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without vacancy");
  property p_flush; $fell(flush_n) |-> ##[1:4] !head_valid; endproperty
  a_flush: assert property (p_flush) else $error("flush kept head valid");
  property p_flush_data; $fell(flush_n) |-> ##1 $stable(read_word_out) [*4]; endproperty
  a_flush_data: assert property (p_flush_data) else $error("flush moved data");
  property p_full_hold; (!space_available && unload_strobe_in && flush_n) [*4] |=> !space_available; endproperty
  a_full_hold: assert property (p_full_hold) else $error("space without pop");
  c_full: cover property ($fell(space_available));
  c_pulse: cover property ($fell(unload_pulse_out));
  c_flush: cover property ($fell(flush_n) ##4 !head_valid);
endmodule : fds_fifo_chk

bind fds_fifo fds_fifo_chk i_fds_fifo_chk (.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk),
  .load_strobe_a(load_strobe_a), .load_strobe_b(load_strobe_b), .unload_strobe_in(unload_strobe_in),
  .output_enable_n(output_enable_n), .flush_n(flush_n), .write_word_in(write_word_in),
  .read_word_out(read_word_out), .read_word_oe(read_word_oe), .space_available(space_available),
  .head_valid(head_valid), .unload_pulse_out(unload_pulse_out));

// [test/fds_peer.sv]
// producer and consumer strobing the fifo pins
`timescale 1ns/1ps
module fds_peer
  import fds_pkg::*;
(
  // clocks
  input  wire logic                 clk,
  input  wire logic                 link_clk,
  // strobes and word towards the fifo
  output logic                      load_strobe_a,
  output logic                      load_strobe_b,
  output logic                      unload_strobe_in,
  output logic      [FDS_WIDTH-1:0] write_word_in
);
  initial
  begin
    load_strobe_a = 1'b1;
    load_strobe_b = 1'b1;
    unload_strobe_in = 1'b1;
    write_word_in = 5'h00;
  end

  // one strobe held high as enable, the other makes the edge
  task automatic push(input logic [FDS_WIDTH-1:0] w, input logic use_b);
    @(negedge link_clk);
    write_word_in <= w;
    load_strobe_a <= use_b;
    load_strobe_b <= ~use_b;
    repeat (3) @(negedge link_clk);
    load_strobe_a <= 1'b1;
    load_strobe_b <= 1'b1;
    repeat (3) @(negedge link_clk);
    write_word_in <= ~w;
    repeat (2) @(negedge link_clk);
  endtask : push

  task automatic pop();
    @(negedge clk);
    unload_strobe_in <= 1'b0;
    repeat (3) @(negedge clk);
    unload_strobe_in <= 1'b1;
    repeat (30) @(negedge clk);
  endtask : pop
endmodule : fds_peer

// [test/tb_top.sv]
// self-checking bench for the dual-strobe fifo
`timescale 1ns/1ps
module tb_top;
  import fds_pkg::*;
  logic                 clk = 1'b0, link_clk = 1'b0, sys_rst = 1'b1, oe_n = 1'b0, flush_n = 1'b1;
  logic                 la, lb, ul, sp, hv, upo, hv_q = 1'b0, upo_q = 1'b1;
  logic [FDS_WIDTH-1:0] wd, rd, oe, prev;
  logic [FDS_WIDTH-1:0] exp_q[$];
  int                   num_errors = 0, compares = 0, occ = 0, pulses = 0;

  always #2 clk = ~clk;
  initial
  begin
    #7;
    forever #15 link_clk = ~link_clk;
  end

  fds_fifo i_fds_fifo (.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk), .load_strobe_a(la),
    .load_strobe_b(lb), .write_word_in(wd), .unload_strobe_in(ul), .output_enable_n(oe_n),
    .flush_n(flush_n), .read_word_out(rd), .read_word_oe(oe), .space_available(sp),
    .head_valid(hv), .unload_pulse_out(upo));
  fds_peer i_fds_peer (.clk(clk), .link_clk(link_clk), .load_strobe_a(la), .load_strobe_b(lb),
    .unload_strobe_in(ul), .write_word_in(wd));

  task automatic fail(input string msg);
    num_errors++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask : fail

  task automatic complete_run();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // refused loads are not noted, so the queue mirrors what may come out
  task automatic put(input logic [FDS_WIDTH-1:0] w);
    if (occ < FDS_DEPTH)
    begin
      exp_q.push_back(w);
      occ++;
    end
    i_fds_peer.push(w, w[0]);
  endtask : put

  task automatic take();
    if (occ > 0)
      occ--;
    i_fds_peer.pop();
  endtask : take

  // every new valid head is the oldest note
  always @(negedge clk)
  begin
    hv_q  <= hv;
    upo_q <= upo;
    if (!sys_rst && upo_q === 1'b1 && upo === 1'b0)
      pulses++;
    if (!sys_rst && hv === 1'b1 && hv_q === 1'b0)
    begin
      compares++;
      if (exp_q.size() == 0)
        fail("head without word");
      else if (rd !== exp_q.pop_front())
        fail("head word");
    end
  end

  initial
  begin
    #200000;
    num_errors++;
    complete_run();
  end

  initial
  begin
    void'($urandom(32'h5961));
    // long enough for the link side to see reset too
    repeat (32) @(negedge clk);
    sys_rst = 1'b0;
    repeat (10) @(negedge clk);
    for (int i = 0; i < 17; i++)
      put(5'($urandom));
    repeat (20) @(negedge clk);
    compares++;
    if (sp !== 1'b0)
      fail("full");
    for (int i = 0; i < 17; i++)
      take();
    compares++;
    if (sp !== 1'b1 || exp_q.size() != 0)
      fail("drained");
    // exactly one vacancy of the last location so far: the first pop from full
    compares++;
    if (pulses != 1)
      fail("unload pulse count");
    $display("test fill_drain done");
    for (int i = 0; i < 3; i++)
      put(5'($urandom));
    repeat (10) @(negedge clk);
    prev = rd;
    flush_n = 1'b0;
    repeat (12) @(negedge clk);
    flush_n = 1'b1;
    compares++;
    if (hv !== 1'b0 || rd !== prev || sp !== 1'b1 || pulses != 1)
      fail("flush");
    exp_q.delete();
    occ = 0;
    fork
      put(5'h15);
      take();
    join
    take();
    compares++;
    if (exp_q.size() != 0)
      fail("after flush");
    $display("test flush done");
    for (int i = 0; i < 8; i++)
    begin
      oe_n = 1'($urandom);
      repeat (6) @(negedge clk);
      compares++;
      if (oe !== {FDS_WIDTH{~oe_n}})
        fail("output enable");
    end
    $display("test output_enable done");
    complete_run();
  end
endmodule : tb_top
